/* File: sbp_pkg.sv */
/*
  Package for the six-pin bidirectional port: register offsets,
  reset values, field widths and the pad-side carrier struct.
  Assumes a 32-bit APB with byte addresses and one word per register.
*/
`default_nettype none

package sbp_pkg;

  // Port geometry
  localparam int unsigned NPIN   = 6;
  localparam int unsigned AW     = 12;
  localparam int unsigned DW     = 32;
  localparam int unsigned SYNC_N = 3;

  // Register byte offsets
  localparam logic [AW-1:0] OFF_PIN_VALUE  = 12'h000;
  localparam logic [AW-1:0] OFF_OUT_LATCH  = 12'h004;
  localparam logic [AW-1:0] OFF_DIR_MASK   = 12'h008;
  localparam logic [AW-1:0] OFF_ANALOG_SEL = 12'h00C;
  localparam logic [AW-1:0] OFF_OPEN_DRAIN = 12'h010;
  localparam logic [AW-1:0] OFF_SLEW_LIMIT = 12'h014;
  localparam logic [AW-1:0] OFF_THRESH_SEL = 12'h018;

  // Reset values: all inputs, push-pull, fast, digital, Schmitt
  localparam logic [NPIN-1:0] DIR_RST  = 6'h3F;
  localparam logic [NPIN-1:0] CTL_RST  = 6'h00;
  localparam logic [NPIN-1:0] VEC_ZERO = 6'h00;
  localparam logic [DW-1:0]   WORD_ZERO = 32'h0000_0000;

  // Byte lane that carries the six port bits
  localparam int unsigned LANE_PORT = 0;

  typedef logic [NPIN-1:0] sbp_vec_t;

  // Everything the block drives toward the pad ring
  typedef struct packed {
    sbp_vec_t out;     // Level driven when enabled
    sbp_vec_t oe;      // High while the pad is driven
    sbp_vec_t slew;    // High selects slew-limited drive
    sbp_vec_t analog;  // High disables the digital input buffer
    sbp_vec_t ttl;     // High selects TTL threshold, low Schmitt
  } sbp_pad_t;

  // Software-visible configuration
  typedef struct packed {
    sbp_vec_t latch;
    sbp_vec_t dir;
    sbp_vec_t analog;
    sbp_vec_t odrain;
    sbp_vec_t slew;
    sbp_vec_t thresh;
  } sbp_cfg_t;

endpackage : sbp_pkg

`default_nettype wire

/* File: sbp_port.sv */
/*
  Six-pin bidirectional port with an APB register slave: direction,
  output latch, pin readback with read-modify-write, analog select,
  open-drain, slew limit and input threshold per pin.
  Assumes the pad ring resolves the wire from out/oe, supplies the
  comparator outputs for both input thresholds, and that an I2C
  peripheral reports which pins it owns and when it pulls them low.
  Assumes the I2C signals come from logic on this clock, so they
  take no synchroniser, while both comparator outputs are
  asynchronous and pass three flops.
  Assumes an APB master that keeps a request steady until pready.
*/
// The implementer's own choices: the address map and the APB interface to the registers.
//
// Summary of operation
// R01 - Six pins, each individually an input or an output.
// R02 - Direction bit 1 turns the driver off; 0 drives the output latch.
// R03 - Pin value reads return pins; writes land in the output latch.
// R04 - Pin value writes sample pins, merge written bits, store in latch.
// R05 - Output latch holds the latest write through either register.
// R06 - Direction governs drivers on analog pins too; analog pins read zero.
// R07 - Software keeps direction set on pins used as analog inputs.
// R08 - Open-drain bit set: sink only; cleared: push-pull drive.
// R09 - Pins owned by I2C are always open-drain.
// R10 - Slew bit set limits slew rate; cleared gives fastest edges.
// R11 - Threshold bit picks Schmitt or TTL for readback and change detect.
// R12 - Software changes thresholds only while peripherals are disabled.
// R13 - Reset leaves every pin an input with push-pull drive selected.

`timescale 1ns/1ps
`default_nettype none

module sbp_port (
  input  wire logic                    I_CORE_CLK,
  input  wire logic                    I_ARST_N,
  // APB slave
  input  wire logic                    I_PSEL,
  input  wire logic                    I_PENABLE,
  input  wire logic                    I_PWRITE,
  input  wire logic [sbp_pkg::AW-1:0]  I_PADDR,
  input  wire logic [sbp_pkg::DW-1:0]  I_PWDATA,
  input  wire logic [3:0]              I_PSTRB,
  output logic                         O_PREADY,
  output logic                         O_PSLVERR,
  output logic [sbp_pkg::DW-1:0]       O_PRDATA,
  // Pad side
  input  wire logic [sbp_pkg::NPIN-1:0] I_PAD_ST,
  input  wire logic [sbp_pkg::NPIN-1:0] I_PAD_TTL,
  output sbp_pkg::sbp_pad_t             O_PAD,
  // I2C pin ownership
  input  wire logic [sbp_pkg::NPIN-1:0] I_I2C_OWN,
  input  wire logic [sbp_pkg::NPIN-1:0] I_I2C_PULL_LOW,
  // Settled, threshold-selected levels for change detection
  output logic [sbp_pkg::NPIN-1:0]      O_PIN_LEVEL
);

  // Byte enable of the lane that holds the port bits
  function automatic logic lane_on(input logic [3:0] strb);
    lane_on = strb[sbp_pkg::LANE_PORT];
  endfunction : lane_on

  // Word written on lane 0 merged over a background value
  function automatic sbp_pkg::sbp_vec_t merge(
    input sbp_pkg::sbp_vec_t                bg,
    input logic [sbp_pkg::DW-1:0]           wd,
    input logic [3:0]                       strb
  );
    merge = lane_on(strb) ? wd[sbp_pkg::NPIN-1:0] : bg;
  endfunction : merge

  // Zero-extend a port vector to a bus word
  function automatic logic [sbp_pkg::DW-1:0] widen(
    input sbp_pkg::sbp_vec_t v
  );
    widen = {{(sbp_pkg::DW-sbp_pkg::NPIN){1'b0}}, v};
  endfunction : widen

  // A bit changes only once the last two stages agree
  function automatic sbp_pkg::sbp_vec_t settle(
    input sbp_pkg::sbp_vec_t s2,
    input sbp_pkg::sbp_vec_t s3,
    input sbp_pkg::sbp_vec_t cur
  );
    settle = (s2 & s3) | (cur & (s2 | s3));
  endfunction : settle

  // One register select; exact match, so unaligned or out-of-range
  // addresses select nothing and fall through to the error answer
  function automatic logic at_off(
    input logic [sbp_pkg::AW-1:0] addr,
    input logic [sbp_pkg::AW-1:0] off
  );
    at_off = (addr == off);
  endfunction : at_off

  // Bus phase decode
  logic setup_ph;
  logic access_ph;
  logic wr_go;
  logic hit_pin;
  logic hit_lat;
  logic hit_dir;
  logic hit_ana;
  logic hit_od;
  logic hit_slw;
  logic hit_thr;
  logic hit_any;

  assign setup_ph  = I_PSEL & ~I_PENABLE;
  assign access_ph = I_PSEL & I_PENABLE;
  // Register map, one word each, bits 5:0 used, 31:6 read as zero:
  //   pin value      reads pins, writes the latch via merge
  //   output latch   plain read/write of the latch
  //   direction      1 = input, driver off
  //   analog select  1 = digital input off, pin reads zero
  //   open drain     1 = sink only
  //   slew limit     1 = limited edge rate
  //   threshold      1 = TTL, 0 = Schmitt
  assign hit_pin   = at_off(I_PADDR, sbp_pkg::OFF_PIN_VALUE);
  assign hit_lat   = at_off(I_PADDR, sbp_pkg::OFF_OUT_LATCH);
  assign hit_dir   = at_off(I_PADDR, sbp_pkg::OFF_DIR_MASK);
  assign hit_ana   = at_off(I_PADDR, sbp_pkg::OFF_ANALOG_SEL);
  assign hit_od    = at_off(I_PADDR, sbp_pkg::OFF_OPEN_DRAIN);
  assign hit_slw   = at_off(I_PADDR, sbp_pkg::OFF_SLEW_LIMIT);
  assign hit_thr   = at_off(I_PADDR, sbp_pkg::OFF_THRESH_SEL);
  assign hit_any   = hit_pin | hit_lat | hit_dir | hit_ana |
                     hit_od | hit_slw | hit_thr;
  // Writes commit only at the access edge, and only when mapped
  assign wr_go     = access_ph & I_PWRITE & hit_any;

  // Input path state
  sbp_pkg::sbp_vec_t sel_raw;
  sbp_pkg::sbp_vec_t s1_q;
  sbp_pkg::sbp_vec_t s2_q;
  sbp_pkg::sbp_vec_t s3_q;
  sbp_pkg::sbp_vec_t lvl_q;
  sbp_pkg::sbp_vec_t s1_d;
  sbp_pkg::sbp_vec_t s2_d;
  sbp_pkg::sbp_vec_t s3_d;
  sbp_pkg::sbp_vec_t lvl_d;
  sbp_pkg::sbp_vec_t rd_pins;

  // Configuration state; the latch sits beside the controls so
  // both data registers share one copy
  sbp_pkg::sbp_cfg_t cfg_q;
  sbp_pkg::sbp_cfg_t cfg_d;

  // Read path state
  logic [sbp_pkg::DW-1:0] rdata_q;
  logic [sbp_pkg::DW-1:0] rdata_d;
  logic                   err_q;
  logic                   err_d;

  // Threshold chooses which comparator feeds both readback and
  // change detection, so the two can never disagree.
  assign sel_raw = (cfg_q.thresh & I_PAD_TTL) |        // R11
                   (~cfg_q.thresh & I_PAD_ST);         // R11

  // Three-stage synchroniser; stage one feeds only stage two.
  // A threshold switch may glitch here; software avoids that window.
  // The level moves only when stages two and three agree, so a
  // one-cycle glitch never reaches readback; the price is four
  // edges from pin to level.
  always_comb begin
    s1_d  = sel_raw;
    s2_d  = s1_q;
    s3_d  = s2_q;
    lvl_d = settle(s2_q, s3_q, lvl_q);
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s1_q  <= sbp_pkg::VEC_ZERO;
      s2_q  <= sbp_pkg::VEC_ZERO;
      s3_q  <= sbp_pkg::VEC_ZERO;
      lvl_q <= sbp_pkg::VEC_ZERO;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  // Analog pins read as zero whatever the pad shows. The same masked
  // view is what a pin-value write merges into the latch, so an
  // analog pin picks up a zero in the latch on such a write with lane 0 strobe clear.
  assign rd_pins     = lvl_q & ~cfg_q.analog;          // R06
  // Change detection sees the digital view of the pins
  assign O_PIN_LEVEL = rd_pins;                        // R11

  // Register updates. Both data registers write the same latch, so
  // whichever was written last is what it holds.
  always_comb begin
    cfg_d = cfg_q;
    if (wr_go) begin
      if (hit_pin) begin
        // Read the pins, lay the written byte over them
        cfg_d.latch = merge(rd_pins, I_PWDATA, I_PSTRB);   // R03 R04 R05
      end
      if (hit_lat) begin
        // Plain latch write; pins are not sampled
        cfg_d.latch = merge(cfg_q.latch, I_PWDATA, I_PSTRB); // R05
      end
      if (hit_dir) begin
        // Per-pin direction, each bit on its own
        cfg_d.dir = merge(cfg_q.dir, I_PWDATA, I_PSTRB);   // R01
      end
      if (hit_ana) begin
        // Analog select masks readback and change detection, not the drivers
        cfg_d.analog = merge(cfg_q.analog, I_PWDATA, I_PSTRB);
      end
      if (hit_od) begin
        // Open-drain select
        cfg_d.odrain = merge(cfg_q.odrain, I_PWDATA, I_PSTRB);
      end
      if (hit_slw) begin
        // Slew select goes straight to the pad
        cfg_d.slew = merge(cfg_q.slew, I_PWDATA, I_PSTRB);
      end
      if (hit_thr) begin
        // Threshold select steers the comparator mux
        cfg_d.thresh = merge(cfg_q.thresh, I_PWDATA, I_PSTRB);
      end
    end
  end

  // Reset: all pins inputs, push-pull, fast, digital, Schmitt
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg_q.latch  <= sbp_pkg::CTL_RST;
      cfg_q.dir    <= sbp_pkg::DIR_RST;                // R13
      cfg_q.analog <= sbp_pkg::CTL_RST;
      cfg_q.odrain <= sbp_pkg::CTL_RST;                // R13
      cfg_q.slew   <= sbp_pkg::CTL_RST;
      cfg_q.thresh <= sbp_pkg::CTL_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Read data is captured in the setup cycle so it leaves a flop;
  // the cost is that pins are sampled one cycle before the answer.
  // Unmapped addresses flag an error and return zero; a write
  // answers the same way but leaves the read data at zero.
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup_ph) begin
      err_d   = ~hit_any;
      rdata_d = sbp_pkg::WORD_ZERO;
      if (!I_PWRITE) begin
        unique case (1'b1)
          hit_pin: rdata_d = widen(rd_pins);           // R03
          hit_lat: rdata_d = widen(cfg_q.latch);
          hit_dir: rdata_d = widen(cfg_q.dir);
          hit_ana: rdata_d = widen(cfg_q.analog);
          hit_od:  rdata_d = widen(cfg_q.odrain);
          hit_slw: rdata_d = widen(cfg_q.slew);
          hit_thr: rdata_d = widen(cfg_q.thresh);
          default: rdata_d = sbp_pkg::WORD_ZERO;       // Unmapped
        endcase
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_q <= sbp_pkg::WORD_ZERO;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // Zero wait states; error only in the access phase, so a master
  // that samples it with pready sees it exactly once
  assign O_PREADY  = 1'b1;
  assign O_PRDATA  = rdata_q;
  assign O_PSLVERR = access_ph & err_q;

  // Port-owned enables. Direction gates every GPIO driver, analog pins
  // included, so an analog pin left with direction clear is still
  // driven. Open drain with the latch high lets go of the pin.
  sbp_pkg::sbp_vec_t gpio_oe;
  sbp_pkg::sbp_vec_t i2c_oe;

  assign gpio_oe = ~cfg_q.dir & ~I_I2C_OWN &           // R02 R06
                   (~cfg_q.odrain | ~cfg_q.latch);     // R08
  // I2C-owned pins only ever pull low, never source, whatever the
  // open-drain and direction bits say
  assign i2c_oe  = I_I2C_OWN & I_I2C_PULL_LOW;         // R09

  // Pad drive; the out level on an owned pin is zero, so enabling
  // it can only sink
  always_comb begin
    O_PAD.out    = cfg_q.latch & ~I_I2C_OWN;           // R02
    O_PAD.oe     = gpio_oe | i2c_oe;                   // R09
    O_PAD.slew   = cfg_q.slew;                         // R10
    O_PAD.analog = cfg_q.analog;
    O_PAD.ttl    = cfg_q.thresh;                       // R11
  end

endmodule : sbp_port

`default_nettype wire

/* File: sbp_port_props.sv */
/* Checker for the port: APB answers, pad drive and settled pin levels.
   Assumes it is bound to sbp_port and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module sbp_port_props (
  input wire logic              I_CORE_CLK,
  input wire logic              I_ARST_N,
  input wire logic              I_PSEL,
  input wire logic              I_PENABLE,
  input wire logic              I_PWRITE,
  input wire logic [11:0]       I_PADDR,
  input wire logic              O_PSLVERR,
  input wire logic [31:0]       O_PRDATA,
  input wire logic [5:0]        I_PAD_ST,
  input wire logic [5:0]        I_PAD_TTL,
  input wire sbp_pkg::sbp_pad_t O_PAD,
  input wire logic [5:0]        I_I2C_OWN,
  input wire logic [5:0]        I_I2C_PULL_LOW,
  input wire logic [5:0]        O_PIN_LEVEL
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  // Access phase and address decode
  wire acc    = I_PSEL && I_PENABLE;
  wire mapped = I_PADDR <= 12'h018 && I_PADDR[1:0] == 2'h0;
  property p_err; acc |-> O_PSLVERR == !mapped; endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_hi; acc && !I_PWRITE |-> O_PRDATA[31:6] == 26'h0 && (mapped || O_PRDATA == 0);
  endproperty
  a_hi: assert property (p_hi) else $error("read data wrong");
  property p_ana; acc && !I_PWRITE && I_PADDR == sbp_pkg::OFF_PIN_VALUE |->
    (O_PRDATA[5:0] & O_PAD.analog) == 6'h00; endproperty
  a_ana: assert property (p_ana) else $error("analog pin reads high");
  property p_own; ((O_PAD.oe ^ I_I2C_PULL_LOW | O_PAD.out) & I_I2C_OWN) == 6'h00; endproperty
  a_own: assert property (p_own) else $error("i2c pin not open drain");
  property p_rst; $rose(I_ARST_N) && I_I2C_OWN == 6'h00 |-> (O_PAD.oe | O_PAD.slew
    | O_PAD.ttl | O_PAD.analog) == 6'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // Both comparators stable long enough must show the chosen one
  property p_lvl; (O_PAD.analog == 6'h00 && $stable(O_PAD.ttl) && $stable(I_PAD_ST)
    && $stable(I_PAD_TTL))[*5] |-> O_PIN_LEVEL == (O_PAD.ttl & I_PAD_TTL | ~O_PAD.ttl & I_PAD_ST);
  endproperty
  a_lvl: assert property (p_lvl) else $error("pin level wrong");
  property p_out; $changed(O_PAD.out) |-> $past(acc && I_PWRITE) || $changed(I_I2C_OWN);
  endproperty
  a_out: assert property (p_out) else $error("latch moved unwritten");
  property p_slew; $changed(O_PAD.slew) |-> $past(acc && I_PWRITE
    && I_PADDR == sbp_pkg::OFF_SLEW_LIMIT); endproperty
  a_slew: assert property (p_slew) else $error("slew moved unwritten");
  property p_ttl; $changed(O_PAD.ttl) |-> $past(acc && I_PWRITE
    && I_PADDR == sbp_pkg::OFF_THRESH_SEL); endproperty
  a_ttl: assert property (p_ttl) else $error("threshold moved unwritten");
endmodule : sbp_port_props
bind sbp_port sbp_port_props u_props (.I_CORE_CLK, .I_ARST_N, .I_PSEL, .I_PENABLE, .I_PWRITE,
  .I_PADDR, .O_PSLVERR, .O_PRDATA, .I_PAD_ST, .I_PAD_TTL, .O_PAD, .I_I2C_OWN, .I_I2C_PULL_LOW,
  .O_PIN_LEVEL);
`default_nettype wire

/* File: sbp_pads.sv */
/* Board and pad model: resolves each pin, feeds both comparators.
   Assumes undriven pins float up to a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module sbp_pads (
  input  wire sbp_pkg::sbp_pad_t i_pad,
  input  wire logic [5:0]        i_ext_en,
  input  wire logic [5:0]        i_ext_val,
  input  wire logic [5:0]        i_mid,
  output logic [5:0]             o_st,
  output logic [5:0]             o_ttl
);
  logic [5:0] lvl;
  // Driven pins win; released ones take the board or the pull-up
  assign lvl   = i_pad.oe & i_pad.out | ~i_pad.oe & (i_ext_en & i_ext_val | ~i_ext_en);
  // Level between thresholds reads opposite on TTL
  assign o_st  = lvl;
  assign o_ttl = lvl ^ i_mid;
endmodule : sbp_pads
`default_nettype wire

/* File: sbp_port_bench.sv */
/* Self-checking bench for the port over APB with a pad model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`default_nettype none
module sbp_port_bench;
  logic clk, rst_n, psel, pen, pwr, prdy, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [5:0] ext_en, ext_val, mid, own, pl, st, ttl, lvl, dir, lat, an, od, th, r;
  logic [33:0] note;
  logic [33:0] q[$];
  int fail_count, check_count;
  sbp_pkg::sbp_pad_t pad;
  sbp_port dut (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(prdy),
    .O_PSLVERR(perr), .O_PRDATA(prdata), .I_PAD_ST(st), .I_PAD_TTL(ttl), .O_PAD(pad),
    .I_I2C_OWN(own), .I_I2C_PULL_LOW(pl), .O_PIN_LEVEL(lvl));
  sbp_pads pads (.i_pad(pad), .i_ext_en(ext_en), .i_ext_val(ext_val), .i_mid(mid),
    .o_st(st), .o_ttl(ttl));
  // Clock
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task complete_run;
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task chkw(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chkw
  task chkv(input string n, input logic [5:0] e, input logic [5:0] g);
    chkw(n, {26'h0, e}, {26'h0, g});
  endtask : chkv
  // Expected drive and readback, from the bench's own register copy
  function automatic logic [5:0] oe_x();
    return ~dir & ~own & (~od | ~lat) | own & pl;
  endfunction : oe_x
  function automatic logic [5:0] rd_x();
    logic [5:0] v;
    v = oe_x() & lat & ~own | ~oe_x() & (ext_en & ext_val | ~ext_en);
    return (v ^ (th & mid)) & ~an;
  endfunction : rd_x
  // One APB transfer; the note goes in before the request
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic s,
    input logic [5:0] e);
    q.push_back({~w, a > 12'h018 || a[1:0] != 2'h0, 26'h0, e});
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 3'h0, s};
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    {psel, pen} <= 2'b00;
  endtask : apb
  task rd(input logic [11:0] a, input logic [5:0] e);
    apb(0, a, 32'h0000_0000, 1, e);
  endtask : rd
  task wr(input logic [11:0] a, input logic [5:0] d);
    apb(1, a, {26'h3FF_FFFF, d}, 1, 6'h00);
  endtask : wr
  // Access-phase watcher pairs each answer with the oldest note
  always @(posedge clk) begin
    if (psel && pen && prdy === 1'b1) begin
      note = q.pop_front();
      chkv("pslverr", {5'h0, note[32]}, {5'h0, perr});
      if (note[33]) chkw("prdata", note[31:0], prdata);
    end
  end
  // Watchdog far beyond the roughly 125 cycles needed
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    {psel, pen, pwr, paddr, pwdata, pstrb, ext_en, ext_val, mid, own, pl} = '0;
    {dir, lat, an, od, th} = {6'h3F, 24'h00_0000};
    rst_n = 0;
    void'($urandom(676));
    repeat (3) @(posedge clk);
    rst_n <= 1;
    // Pins need four edges through the synchroniser before a read
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++) rd(12'(i * 4), (i == 0 || i == 2) ? 6'h3F : 6'h00);
    chkv("oe", 6'h00, pad.oe);
    lat = 6'($urandom);
    wr(12'h004, lat);
    dir = 6'h38;
    wr(12'h008, dir);
    ext_en <= 6'h38;
    ext_val <= 6'($urandom);
    repeat (6) @(posedge clk);
    chkv("oe", oe_x(), pad.oe);
    chkv("out", lat, pad.out);
    rd(12'h000, rd_x());
    apb(1, 12'h000, 32'hFFFF_FFFF, 0, 6'h00);
    lat = rd_x();
    rd(12'h004, lat);
    lat = 6'($urandom);
    wr(12'h000, lat);
    rd(12'h004, lat);
    an = 6'h28;
    wr(12'h00C, an);
    repeat (6) @(posedge clk);
    rd(12'h000, rd_x());
    chkv("oe", oe_x(), pad.oe);
    chkv("analog", an, pad.analog);
    od = 6'h3F;
    wr(12'h010, od);
    @(posedge clk);
    chkv("oe", oe_x(), pad.oe);
    for (int i = 0; i < 2; i++) begin
      {own, pl} <= {6'h01, 6'(i)};
      @(posedge clk);
      @(posedge clk);
      chkv("oe", oe_x(), pad.oe);
      chkv("out", lat & ~own, pad.out);
    end
    own <= 6'h00;
    r = 6'($urandom);
    wr(12'h014, r);
    @(posedge clk);
    chkv("slew", r, pad.slew);
    mid <= 6'h3F;
    th = 6'h15;
    wr(12'h018, th);
    repeat (6) @(posedge clk);
    rd(12'h000, rd_x());
    chkv("ttl", th, pad.ttl);
    chkv("level", rd_x(), lvl);
    rd(12'h01C, 6'h00);
    wr(12'h020, 6'h00);
    // Readback of every control, then a strobe-less control write
    rd(12'h008, dir);
    rd(12'h00C, an);
    rd(12'h010, od);
    rd(12'h014, r);
    rd(12'h018, th);
    apb(1, 12'h008, 32'h0000_0000, 0, 6'h00);
    rd(12'h008, dir);
    rd(12'h004, lat);
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule : sbp_port_bench
`default_nettype wire
